// File: rtl/fpc_pkg.sv
// fpc_pkg: constants and types of the flash protection command controller
package fpc_pkg;

  // ----------------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_MHZ          = 125;
  localparam int ADDR_SETUP_NS    = 16;
  localparam int WE_PULSE_NS      = 40;
  localparam int READ_ACCESS_NS   = 80;
  localparam int BUS_HOLD_NS      = 16;
  localparam int PORTION_GAP_NS   = 2000;
  localparam int BUSY_SETTLE_NS   = 200;
  localparam int TIMEOUT_US       = 1000;
  // least times round up
  localparam int SETUP_CYC_I  = (ADDR_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int WE_CYC_I     = (WE_PULSE_NS * CLK_MHZ + 999) / 1000;
  // two extra cycles cover the data synchroniser
  localparam int RD_CYC_I     = (READ_ACCESS_NS * CLK_MHZ + 999) / 1000 + 2;
  localparam int HOLD_CYC_I   = (BUS_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int GAP_CYC_I    = (PORTION_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int SETTLE_CYC_I = (BUSY_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam int TIMEOUT_CYC  = TIMEOUT_US * CLK_MHZ;
  localparam logic [7:0]  SETUP_CYC  = 8'(SETUP_CYC_I);
  localparam logic [7:0]  WE_CYC     = 8'(WE_CYC_I);
  localparam logic [7:0]  RD_CYC     = 8'(RD_CYC_I);
  localparam logic [7:0]  HOLD_CYC   = 8'(HOLD_CYC_I);
  localparam logic [8:0]  GAP_CYC    = 9'(GAP_CYC_I);
  localparam logic [23:0] SETTLE_CYC = 24'(SETTLE_CYC_I);

  // ----------------------------------------------------------------------
  // flash command cycles
  // ----------------------------------------------------------------------
  localparam logic [10:0] UNLOCK_ADDR1   = 11'h555;
  localparam logic [10:0] UNLOCK_ADDR2   = 11'h2AA;
  localparam logic [7:0]  UNLOCK_DATA1   = 8'hAA;
  localparam logic [7:0]  UNLOCK_DATA2   = 8'h55;
  localparam logic [7:0]  CMD_RESET      = 8'hF0;
  localparam logic [7:0]  CMD_PPB_PGM    = 8'h60;
  localparam logic [7:0]  DYB_SET_CODE   = 8'h01;
  localparam logic [7:0]  DYB_CLR_CODE   = 8'h00;
  // entry and action codes below are plain defaults, adjust per part
  localparam logic [7:0]  CMD_DYB_ENTRY  = 8'hE0;
  localparam logic [7:0]  CMD_PPB_ENTRY  = 8'hC0;
  localparam logic [7:0]  CMD_FRZ_ENTRY  = 8'h50;
  localparam logic [7:0]  CMD_UNLOCK     = 8'h28;
  localparam logic [7:0]  CMD_PWMODE     = 8'h48;
  localparam logic [7:0]  CMD_PSMODE     = 8'h49;
  localparam logic [7:0]  CMD_SECBIT     = 8'h4A;
  localparam logic [7:0]  CMD_ERASE      = 8'h30;
  localparam logic [7:0]  CMD_BIT_PGM    = 8'hA0;
  localparam logic [7:0]  CMD_VERIFY     = 8'h40;
  localparam logic [7:0]  CMD_PPB_STAT   = 8'h41;
  localparam logic [7:0]  CMD_FRZ_STAT   = 8'h58;
  localparam logic [7:0]  CMD_PROT_STAT  = 8'h59;
  localparam logic [1:0]  PW_LAST_IDX    = 2'h3;
  localparam int          SECT_LSB       = 12;
  localparam int          ADDR_BIT_SIX   = 6;

  // ----------------------------------------------------------------------
  // register map (word index on the avalon address)
  // ----------------------------------------------------------------------
  localparam logic [2:0] REG_CTRL   = 3'h0;
  localparam logic [2:0] REG_SECTOR = 3'h1;
  localparam logic [2:0] REG_PW_LO  = 3'h2;
  localparam logic [2:0] REG_PW_HI  = 3'h3;
  localparam logic [2:0] REG_STATUS = 3'h4;
  localparam logic [2:0] REG_RDATA  = 3'h5;
  localparam int CTRL_OP_LSB  = 0;
  localparam int CTRL_GO      = 8;
  localparam int CTRL_DYB_SET = 9;
  localparam int CTRL_PREPROG = 10;
  localparam int STAT_BUSY    = 0;
  localparam int STAT_DONE    = 1;
  localparam int STAT_TIMEOUT = 2;
  localparam int STAT_REFUSED = 3;

  typedef enum logic [3:0] {
    OP_RESET, OP_DYB, OP_PPB_PGM, OP_PPB_ERASE, OP_FRZ_SET, OP_UNLOCK,
    OP_PWMODE, OP_PSMODE, OP_SECBIT, OP_PPB_STAT, OP_FRZ_STAT, OP_PROT_STAT
  } fpc_op_t;

endpackage : fpc_pkg

// File: rtl/fpc_bus_cycle.sv
// fpc_bus_cycle: one asynchronous flash read or write cycle on the pins
`timescale 1ns/1ps
module fpc_bus_cycle (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // cycle request
  input  wire logic        i_req,
  input  wire logic        i_rd,
  input  wire logic [22:0] i_addr,
  input  wire logic [15:0] i_data,
  output logic             o_done,
  output logic [15:0]      o_rdata,
  // flash pins
  input  wire logic [15:0] i_dq,
  output logic [22:0]      o_addr,
  output logic [15:0]      o_dq,
  output logic             o_dq_oe,
  output logic             o_ce_n,
  output logic             o_oe_n,
  output logic             o_we_n
);
  import fpc_pkg::*;

  typedef enum logic [1:0] {PH_IDLE, PH_SETUP, PH_STROBE, PH_HOLD} fpc_ph_t;

  fpc_ph_t     phase;
  logic [7:0]  cnt;
  logic        rd;
  logic [15:0] dq_meta;
  logic [15:0] dq_sync;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      dq_meta <= 16'h0000;
      dq_sync <= 16'h0000;
    end else begin
      dq_meta <= i_dq;
      dq_sync <= dq_meta;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      phase   <= PH_IDLE;
      cnt     <= 8'h00;
      rd      <= 1'b0;
      o_done  <= 1'b0;
      o_rdata <= 16'h0000;
      o_addr  <= 23'h000000;
      o_dq    <= 16'h0000;
      o_dq_oe <= 1'b0;
      o_ce_n  <= 1'b1;
      o_oe_n  <= 1'b1;
      o_we_n  <= 1'b1;
    end else begin
      o_done <= 1'b0;
      unique case (phase)
        PH_IDLE: if (i_req) begin
          o_addr  <= i_addr;
          o_dq    <= i_data;
          o_dq_oe <= ~i_rd;
          rd      <= i_rd;
          o_ce_n  <= 1'b0;
          cnt     <= SETUP_CYC - 8'h01;
          phase   <= PH_SETUP;
        end
        PH_SETUP: if (cnt == 8'h00) begin
          o_oe_n <= ~rd;
          o_we_n <= rd;
          cnt    <= rd ? RD_CYC - 8'h01 : WE_CYC - 8'h01;
          phase  <= PH_STROBE;
        end else begin
          cnt <= cnt - 8'h01;
        end
        PH_STROBE: if (cnt == 8'h00) begin
          if (rd) begin
            o_rdata <= dq_sync;
          end
          o_oe_n <= 1'b1;
          o_we_n <= 1'b1;
          cnt    <= HOLD_CYC - 8'h01;
          phase  <= PH_HOLD;
        end else begin
          cnt <= cnt - 8'h01;
        end
        PH_HOLD: if (cnt == 8'h00) begin
          // data is held past the strobe's rising edge
          o_ce_n  <= 1'b1;
          o_dq_oe <= 1'b0;
          o_done  <= 1'b1;
          phase   <= PH_IDLE;
        end else begin
          cnt <= cnt - 8'h01;
        end
      endcase
    end
  end

endmodule : fpc_bus_cycle

// File: rtl/fpc_host.sv
// fpc_host: host controller issuing sector protection commands to a flash
//
// How it works
// - host ends each mode lock or secured bit program with Read/Reset
// - dynamic bit write: sector on high address, 01h or 00h low byte
// - unlock portions spaced at least 2 us apart; exact 64-bit match; host times the gap only between portions of one unlock command
// - device busy about 1 us per portion; host waits for ready
// - full password unlock sequence is seven write cycles
// - persistent bit program: command 60h, address bit six low, sector
// - after persistent bit program, two cycles check margin
// - host refuses bulk erase unless CTRL_PREPROG is set by software, checks margin
//
// Chosen here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
module fpc_host #(
  parameter int TIMEOUT_CYCLES = fpc_pkg::TIMEOUT_CYC
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // avalon-mm slave
  input  wire logic [2:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  // flash pins
  output logic [22:0]      o_flash_addr,
  output logic [15:0]      o_flash_dq,
  output logic             o_flash_dq_oe,
  input  wire logic [15:0] i_flash_dq,
  output logic             o_flash_ce_n,
  output logic             o_flash_oe_n,
  output logic             o_flash_we_n,
  input  wire logic        i_ready_busy_out
);
  import fpc_pkg::*;

  typedef enum logic [3:0] {
    ST_IDLE, ST_UNL1, ST_UNL2, ST_CMD, ST_GAP, ST_ACT, ST_SETTLE,
    ST_WAITRDY, ST_VFY, ST_RD, ST_RST
  } fpc_st_t;

  fpc_st_t     state;
  fpc_op_t     op;
  logic        issued;
  logic        breq;
  logic        bus_done;
  logic [15:0] bus_rdata;
  logic [1:0]  pidx;
  logic [8:0]  gap_cnt;
  logic [23:0] wait_cnt;
  logic        rdy_meta;
  logic        rdy_sync;
  logic [3:0]  ctrl_op;
  logic        dyb_set;
  logic        preprog_ack;
  logic [10:0] sector;
  logic [63:0] password;
  logic        st_done;
  logic        st_timeout;
  logic        st_refused;
  logic [15:0] rdata;
  logic        go;
  logic        acc;
  logic        next_rd;
  logic [22:0] next_addr;
  logic [15:0] next_data;
  logic        issue_state;

  // ----------------------------------------------------------------------
  // command code of the third unlock cycle
  // ----------------------------------------------------------------------
  function automatic logic [7:0] fpc_entry(input fpc_op_t o);
    unique case (o)
      OP_DYB:       fpc_entry = CMD_DYB_ENTRY;
      OP_PPB_PGM:   fpc_entry = CMD_PPB_ENTRY;
      OP_PPB_ERASE: fpc_entry = CMD_PPB_ENTRY;
      OP_FRZ_SET:   fpc_entry = CMD_FRZ_ENTRY;
      OP_UNLOCK:    fpc_entry = CMD_UNLOCK;
      OP_PWMODE:    fpc_entry = CMD_PWMODE;
      OP_PSMODE:    fpc_entry = CMD_PSMODE;
      OP_SECBIT:    fpc_entry = CMD_SECBIT;
      OP_PPB_STAT:  fpc_entry = CMD_PPB_STAT;
      OP_FRZ_STAT:  fpc_entry = CMD_FRZ_STAT;
      OP_PROT_STAT: fpc_entry = CMD_PROT_STAT;
      default:      fpc_entry = CMD_RESET;
    endcase
  endfunction : fpc_entry

  // ----------------------------------------------------------------------
  // avalon slave: one wait state on every access
  // ----------------------------------------------------------------------
  assign acc = (i_avs_read | i_avs_write) & ~o_avs_waitrequest;
  assign go  = acc & i_avs_write & (i_avs_address == REG_CTRL) &
               i_avs_writedata[CTRL_GO];

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= ~((i_avs_read | i_avs_write) & o_avs_waitrequest);
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_avs_readdata <= 32'h00000000;
    end else if ((i_avs_read | i_avs_write) & o_avs_waitrequest) begin
      unique case (i_avs_address)
        REG_CTRL:   o_avs_readdata <= {21'h000000, preprog_ack, dyb_set,
                                       1'b0, 4'h0, ctrl_op};
        REG_SECTOR: o_avs_readdata <= {21'h000000, sector};
        REG_PW_LO:  o_avs_readdata <= password[31:0];
        REG_PW_HI:  o_avs_readdata <= password[63:32];
        REG_STATUS: o_avs_readdata <= {28'h0000000, st_refused, st_timeout,
                                       st_done, state != ST_IDLE};
        REG_RDATA:  o_avs_readdata <= {16'h0000, rdata};
        default:    o_avs_readdata <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_op     <= 4'h0;
      dyb_set     <= 1'b0;
      preprog_ack <= 1'b0;
      sector      <= 11'h000;
      password    <= 64'hFFFFFFFFFFFFFFFF;
    end else if (acc & i_avs_write) begin
      unique case (i_avs_address)
        REG_CTRL: begin
          ctrl_op     <= i_avs_writedata[CTRL_OP_LSB +: 4];
          dyb_set     <= i_avs_writedata[CTRL_DYB_SET];
          preprog_ack <= i_avs_writedata[CTRL_PREPROG];
        end
        REG_SECTOR: sector <= i_avs_writedata[10:0];
        REG_PW_LO:  password[31:0]  <= i_avs_writedata;
        REG_PW_HI:  password[63:32] <= i_avs_writedata;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // ready pin synchroniser
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdy_meta <= 1'b0;
      rdy_sync <= 1'b0;
    end else begin
      rdy_meta <= i_ready_busy_out;
      rdy_sync <= rdy_meta;
    end
  end

  // ----------------------------------------------------------------------
  // cycle contents per state
  // ----------------------------------------------------------------------
  assign issue_state = state inside {ST_UNL1, ST_UNL2, ST_CMD, ST_ACT,
                                     ST_VFY, ST_RD, ST_RST};

  always_comb begin
    next_rd   = 1'b0;
    next_addr = {sector, 12'h000};
    next_data = 16'h0000;
    unique case (state)
      ST_UNL1: begin
        next_addr = {12'h000, UNLOCK_ADDR1};
        next_data = {8'h00, UNLOCK_DATA1};
      end
      ST_UNL2: begin
        next_addr = {12'h000, UNLOCK_ADDR2};
        next_data = {8'h00, UNLOCK_DATA2};
      end
      ST_CMD: begin
        next_addr = {12'h000, UNLOCK_ADDR1};
        next_data = {8'h00, fpc_entry(op)};
      end
      ST_ACT: begin
        unique case (op)
          OP_DYB: next_data = {8'h00,
                    dyb_set ? DYB_SET_CODE : DYB_CLR_CODE};
          OP_PPB_PGM: begin
            next_addr[ADDR_BIT_SIX] = 1'b0;
            next_data = {8'h00, CMD_PPB_PGM};
          end
          OP_PPB_ERASE: next_data = {8'h00, CMD_ERASE};
          OP_FRZ_SET:   next_data = {8'h00, CMD_BIT_PGM};
          OP_UNLOCK: begin
            next_addr = {21'h000000, pidx};
            next_data = password[{pidx, 4'h0} +: 16];
          end
          OP_PWMODE, OP_PSMODE, OP_SECBIT:
            next_data = {8'h00, CMD_BIT_PGM};
          default: next_rd = 1'b1;
        endcase
      end
      ST_VFY: begin
        next_addr[ADDR_BIT_SIX] = 1'b0;
        next_data = {8'h00, CMD_VERIFY};
      end
      ST_RD:  next_rd = 1'b1;
      ST_RST: next_data = {8'h00, CMD_RESET};
      default: ;
    endcase
  end

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state      <= ST_IDLE;
      op         <= OP_RESET;
      issued     <= 1'b0;
      breq       <= 1'b0;
      pidx       <= 2'h0;
      gap_cnt    <= 9'h000;
      wait_cnt   <= 24'h000000;
      st_done    <= 1'b0;
      st_timeout <= 1'b0;
      st_refused <= 1'b0;
      rdata      <= 16'h0000;
    end else begin
      breq <= 1'b0;
      if (gap_cnt != 9'h000) begin
        gap_cnt <= gap_cnt - 9'h001;
      end
      if (go && state != ST_IDLE) begin
        st_refused <= 1'b1;
      end
      if (issue_state && !issued) begin
        breq   <= 1'b1;
        issued <= 1'b1;
      end
      unique case (state)
        ST_IDLE: if (go) begin
          op         <= fpc_op_t'(i_avs_writedata[CTRL_OP_LSB +: 4]);
          pidx       <= 2'h0;
          st_done    <= 1'b0;
          st_timeout <= 1'b0;
          st_refused <= 1'b0;
          if (fpc_op_t'(i_avs_writedata[CTRL_OP_LSB +: 4]) == OP_PPB_ERASE
              && !i_avs_writedata[CTRL_PREPROG]) begin
            st_refused <= 1'b1;
          end else if (i_avs_writedata[CTRL_OP_LSB +: 4] == 4'(OP_RESET)) begin
            state <= ST_RST;
          end else begin
            state <= ST_UNL1;
          end
        end
        ST_UNL1: if (bus_done) begin
          issued <= 1'b0;
          state  <= ST_UNL2;
        end
        ST_UNL2: if (bus_done) begin
          issued <= 1'b0;
          state  <= ST_CMD;
        end
        ST_CMD: if (bus_done) begin
          issued <= 1'b0;
          state  <= ST_ACT;
        end
        ST_GAP: if (gap_cnt == 9'h000) begin
          state <= ST_ACT;
        end
        ST_ACT: if (bus_done) begin
          issued   <= 1'b0;
          wait_cnt <= 24'h000000;
          if (next_rd) begin
            rdata <= bus_rdata;
          end
          if (op == OP_UNLOCK) begin
            gap_cnt <= GAP_CYC;
          end
          unique case (op)
            OP_DYB, OP_FRZ_SET, OP_PPB_STAT, OP_FRZ_STAT, OP_PROT_STAT:
              state <= ST_RST;
            default: state <= ST_SETTLE;
          endcase
        end
        ST_SETTLE: begin
          // busy may assert late; wait before trusting ready
          wait_cnt <= wait_cnt + 24'h000001;
          if (wait_cnt == SETTLE_CYC) begin
            wait_cnt <= 24'h000000;
            state    <= ST_WAITRDY;
          end
        end
        ST_WAITRDY: begin
          wait_cnt <= wait_cnt + 24'h000001;
          if (rdy_sync) begin
            if (op == OP_UNLOCK && pidx != PW_LAST_IDX) begin
              pidx  <= pidx + 2'h1;
              state <= ST_GAP;
            end else if (op == OP_PPB_PGM || op == OP_PPB_ERASE) begin
              state <= ST_VFY;
            end else begin
              state <= ST_RST;
            end
          end else if (wait_cnt >= 24'(TIMEOUT_CYCLES)) begin
            st_timeout <= 1'b1;
            state      <= ST_RST;
          end
        end
        ST_VFY: if (bus_done) begin
          issued <= 1'b0;
          state  <= ST_RD;
        end
        ST_RD: if (bus_done) begin
          issued <= 1'b0;
          rdata  <= bus_rdata;
          state  <= ST_RST;
        end
        ST_RST: if (bus_done) begin
          issued  <= 1'b0;
          st_done <= 1'b1;
          state   <= ST_IDLE;
        end
      endcase
    end
  end

  fpc_bus_cycle u_bus (
    .i_clk   (i_clk),
    .i_rst   (i_rst),
    .i_req   (breq),
    .i_rd    (next_rd),
    .i_addr  (next_addr),
    .i_data  (next_data),
    .o_done  (bus_done),
    .o_rdata (bus_rdata),
    .i_dq    (i_flash_dq),
    .o_addr  (o_flash_addr),
    .o_dq    (o_flash_dq),
    .o_dq_oe (o_flash_dq_oe),
    .o_ce_n  (o_flash_ce_n),
    .o_oe_n  (o_flash_oe_n),
    .o_we_n  (o_flash_we_n)
  );

endmodule : fpc_host

// File: sim/fpc_host_props.sv
// fpc_host_props: port-level checks of the flash protection controller
`timescale 1ns/1ps
module fpc_host_props (
  // clock, reset and bus
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic        o_avs_waitrequest,
  // flash pins
  input wire logic [22:0] o_flash_addr,
  input wire logic [15:0] o_flash_dq,
  input wire logic        o_flash_dq_oe,
  input wire logic        o_flash_ce_n,
  input wire logic        o_flash_oe_n,
  input wire logic        o_flash_we_n
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // ------
  // pin cycles
  // ------
  sequence s_we_low;
    !o_flash_we_n [*5] ##1 o_flash_we_n;
  endsequence
  sequence s_oe_low;
    !o_flash_oe_n [*8] ##1 !o_flash_oe_n [*4] ##1 o_flash_oe_n;
  endsequence
  property p_wait_one;
    $fell(o_avs_waitrequest) |=> o_avs_waitrequest;
  endproperty
  property p_wait_cause;
    !o_avs_waitrequest |-> $past(i_avs_read || i_avs_write);
  endproperty
  property p_we_pulse;
    $fell(o_flash_we_n) |-> s_we_low;
  endproperty
  property p_we_setup;
    $fell(o_flash_we_n) |-> $past(!o_flash_ce_n, 2) && o_flash_dq_oe;
  endproperty
  property p_wr_hold;
    !o_flash_we_n && $past(!o_flash_we_n) |->
      $stable(o_flash_addr) && $stable(o_flash_dq);
  endproperty
  property p_ce_hold;
    $rose(o_flash_we_n) |-> (!o_flash_ce_n && o_flash_dq_oe) [*2];
  endproperty
  property p_we_gap;
    $rose(o_flash_we_n) |-> o_flash_we_n [*6];
  endproperty
  property p_rd_pulse;
    $fell(o_flash_oe_n) |-> s_oe_low;
  endproperty
  property p_no_clash;
    !o_flash_oe_n |-> o_flash_we_n && !o_flash_dq_oe && !o_flash_ce_n;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("waitrequest low longer than one cycle");
  a_wait_cause: assert property (p_wait_cause)
    else $error("waitrequest low without a request");
  a_we_pulse: assert property (p_we_pulse)
    else $error("write strobe width wrong");
  a_we_setup: assert property (p_we_setup)
    else $error("write strobe without setup");
  a_wr_hold: assert property (p_wr_hold)
    else $error("address or data moved during write strobe");
  a_ce_hold: assert property (p_ce_hold)
    else $error("chip enable released too early");
  a_we_gap: assert property (p_we_gap)
    else $error("write cycles too close");
  a_rd_pulse: assert property (p_rd_pulse)
    else $error("read strobe width wrong");
  a_no_clash: assert property (p_no_clash)
    else $error("read strobe clashes with drive");
endmodule : fpc_host_props
bind fpc_host fpc_host_props i_fpc_host_props (.i_clk, .i_rst, .i_avs_read,
  .i_avs_write, .o_avs_waitrequest, .o_flash_addr, .o_flash_dq,
  .o_flash_dq_oe, .o_flash_ce_n, .o_flash_oe_n, .o_flash_we_n);

// File: sim/fpc_flash_model.sv
// fpc_flash_model: behavioural protection logic of the flash device
`timescale 1ns/1ps
module fpc_flash_model #(
  parameter logic [63:0] PW = 64'h0123_4567_89AB_CDEF
) (
  // flash pins
  input  wire logic [22:0] i_addr,
  input  wire logic [15:0] i_dq,
  input  wire logic        i_ce_n,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  output logic [15:0]      o_dq,
  output logic             o_rdy
);
  logic [15:0] pers = '0, dyn = '0;
  logic        frz = 0, pwm = 0, psm = 0, sec = 0, ok;
  logic [7:0]  ent, d;
  logic [3:0]  s;
  logic [15:0] v;
  int          n = 0, k, nw = 0, seq = 0, viol = 0;
  realtime     tp = -1.0e6;
  initial o_rdy = 1;
  task automatic bsy(input int t);
    o_rdy <= 0;
    o_rdy <= #(t) 1;
  endtask : bsy
  always @* begin
    case (ent)
      8'hC0, 8'h41: v = {15'h0, pers[i_addr[15:12]]};
      8'h50, 8'h58: v = {15'h0, frz | pwm};
      8'h59: v = {15'h0, pers[i_addr[15:12]] | dyn[i_addr[15:12]]};
      default: v = 16'hFFFF;
    endcase
  end
  // released bus shows the inverse so a stale value cannot pass
  assign o_dq = (!i_ce_n && !i_oe_n) ? v : ~v;
  always @(posedge i_we_n) if (!i_ce_n) begin
    s = i_addr[15:12];
    d = i_dq[7:0];
    if (d == 8'hF0) begin
      seq = nw;
      nw = 0;
      n = 0;
      ent = 0;
    end else begin
      nw++;
      if (!o_rdy) viol++;
      case (n)
        0: n = (i_addr[10:0] == 11'h555 && d == 8'hAA) ? 1 : 0;
        1: n = (d == 8'h55) ? 2 : 0;
        2: begin ent = d; n = 3; k = 0; ok = 1; end
        default: case (ent)
          8'hE0: dyn[s] = d[0];
          8'hC0: if (d == 8'h60 && !i_addr[6]) begin
            if (frz && pers[s]) bsy(4000);
            else begin pers[s] = 1; bsy(1000); end
          end else if (d == 8'h30) begin
            if (frz) bsy(4000);
            else begin pers = '0; bsy(1000); end
          end
          8'h28: if ($realtime - tp >= 2000) begin
            tp = $realtime;
            ok &= i_addr[1:0] == k && i_dq == PW[16*k +: 16];
            k++;
            if (k == 4 && ok) frz = 0;
            bsy(1000);
          end else viol++;
          8'h50: begin frz = 1; dyn = pers; end
          8'h48: begin if (!psm) pwm = 1; bsy(1000); end
          8'h49: begin if (!pwm) psm = 1; bsy(1000); end
          8'h4A: begin sec = 1; bsy(1000); end
          default: ;
        endcase
      endcase
    end
  end
endmodule : fpc_flash_model

// File: sim/fpc_host_tb.sv
// fpc_host_tb: self-checking bench of the flash protection controller
`timescale 1ns/1ps
module fpc_host_tb;
  import fpc_pkg::*;
  logic        i_clk, i_rst, rd, wr, rdy, wrq, ce_n, oe_n, we_n, dq_oe;
  logic [2:0]  adr;
  logic [31:0] wd, rdata, q, st;
  logic [22:0] fa;
  logic [15:0] fdq, mdq, ep, ed;
  int          fail_count = 0, n_checks = 0, seed, s, b, i;
  fpc_host #(.TIMEOUT_CYCLES(200)) i_fpc_host (
    .i_clk(i_clk), .i_rst(i_rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .o_avs_readdata(rdata),
    .o_avs_waitrequest(wrq), .o_flash_addr(fa), .o_flash_dq(fdq),
    .o_flash_dq_oe(dq_oe), .i_flash_dq(mdq), .o_flash_ce_n(ce_n),
    .o_flash_oe_n(oe_n), .o_flash_we_n(we_n), .i_ready_busy_out(rdy));
  fpc_flash_model i_fpc_flash_model (.i_addr(fa), .i_dq(fdq),
    .i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .o_dq(mdq), .o_rdy(rdy));
  initial begin
    i_clk = 0;
    forever #4 i_clk = ~i_clk;
  end
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict
  task automatic bus(input logic w, input logic [2:0] a,
                     input logic [31:0] dat);
    int t;
    t = 0;
    @(posedge i_clk);
    rd  <= !w;
    wr  <= w;
    adr <= a;
    wd  <= dat;
    // waitrequest and readdata are taken at the rising edge itself
    do @(posedge i_clk); while (wrq !== 1'b0 && ++t < 50);
    if (wrq !== 1'b0) fail_count++;
    q = rdata;
    rd <= 0;
    wr <= 0;
  endtask : bus
  task automatic op(input logic [3:0] c, input logic [10:0] sct,
                    input logic [2:0] f);
    int t;
    t = 0;
    bus(1, REG_SECTOR, {21'h0, sct});
    bus(1, REG_CTRL, {21'h0, f, 4'h0, c});
    do bus(0, REG_STATUS, '0); while (q[1:0] !== 2'b10 && ++t < 2000);
    if (q[1:0] !== 2'b10) fail_count++;
    st = q;
    bus(0, REG_RDATA, '0);
    chk("seq_idle", i_fpc_flash_model.n, '0);
  endtask : op
  initial begin : watchdog
    #400000;
    fail_count++;
    print_verdict();
  end
  initial begin : main
    seed = 75018;
    i_rst = 1; rd = 0; wr = 0; adr = 0; wd = 0; ed = 0;
    repeat (10) @(posedge i_clk);
    i_rst <= 0;
    bus(0, REG_STATUS, '0);
    chk("status_rst", q, '0);
    bus(1, 3'h7, 32'hFFFF_FFFF);
    bus(0, 3'h7, '0);
    chk("unmapped", q, '0);
    for (i = 0; i < 6; i++) begin
      s = $random(seed) & 15;
      b = $random(seed) & 1;
      op(OP_DYB, 11'(s), {1'b0, b[0], 1'b1});
      ed[s] = b[0];
      chk("dyn", i_fpc_flash_model.dyn, ed);
      chk("dyn_len", i_fpc_flash_model.seq, 32'h4);
    end
    op(OP_PROT_STAT, 11'(s), 3'h1);
    chk("prot", q[15:0], {15'h0, ed[s]});
    $display("test dynamic bits done");
    s = $random(seed) & 15;
    ep = 16'h1 << s;
    op(OP_PPB_PGM, 11'(s), 3'h1);
    chk("pers_one", i_fpc_flash_model.pers, ep);
    op(OP_PPB_STAT, 11'(s), 3'h1);
    chk("pers_stat", q[15:0], 16'h1);
    op(OP_FRZ_SET, '0, 3'h1);
    chk("copy", i_fpc_flash_model.dyn, ep);
    op(OP_FRZ_STAT, '0, 3'h1);
    chk("frz_stat", q[15:0], 16'h1);
    op(OP_DYB, 11'(s), 3'h1);
    chk("dyn_frz", i_fpc_flash_model.dyn, '0);
    op(OP_PPB_PGM, 11'(s), 3'h1);
    chk("pgm_to", st[2], 1'b1);
    repeat (400) @(posedge i_clk);
    op(OP_PPB_ERASE, '0, 3'h5);
    chk("ers_to", st[2], 1'b1);
    chk("ers_keep", i_fpc_flash_model.pers, ep);
    repeat (400) @(posedge i_clk);
    bus(1, REG_CTRL, {21'h0, 3'h1, 4'h0, 4'(OP_PPB_ERASE)});
    bus(0, REG_STATUS, '0);
    chk("refuse", {q[3], q[0]}, 2'b10);
    $display("test freeze done");
    for (i = 0; i < 2; i++) begin
      repeat (260) @(posedge i_clk);
      bus(1, REG_PW_LO, i ? 32'h89AB_CDEF : 32'h89AB_CDEE);
      bus(1, REG_PW_HI, 32'h0123_4567);
      op(OP_UNLOCK, '0, 3'h1);
      chk("unlock", i_fpc_flash_model.frz, i == 0);
      chk("unl_len", i_fpc_flash_model.seq, 32'h7);
    end
    op(OP_PPB_ERASE, '0, 3'h5);
    chk("erase", i_fpc_flash_model.pers, '0);
    $display("test unlock done");
    op(OP_PSMODE, '0, 3'h1);
    op(OP_PWMODE, '0, 3'h1);
    chk("modes", {i_fpc_flash_model.psm, i_fpc_flash_model.pwm},
        2'b10);
    op(OP_SECBIT, '0, 3'h1);
    chk("sec", i_fpc_flash_model.sec, 1'b1);
    chk("sec_len", i_fpc_flash_model.seq, 32'h4);
    op(OP_RESET, '0, 3'h1);
    chk("viol", i_fpc_flash_model.viol, '0);
    $display("test modes done");
    print_verdict();
  end
endmodule : fpc_host_tb
